// *** logic/ucpc_channel.sv ***
// one serial channel pin control: modem outputs, dma requests, irq, direction
// assumes apb master on CLK_I; line side gives received chars and tx takes
//
// How it works
// - mcr bit 0 set drives terminal_ready_n low, else high.
// - mcr bit 1 set drives send_request_n low, else high.
// - reset leaves both modem handshake outputs high.
// - loopback forces both modem handshake outputs high.
// - dma type comes from fcr bit 3 only in fifo mode; else type 0.
// - tx type 0: request low when tx fifo empty, off after first load.
// - tx type 1: request low while any tx fifo slot is free.
// - rx type 0: request low while any received char is held.
// - rx type 1: low at trigger level or timeout, high when empty.
// - read direction output high one cycle after each cpu read setup or access cycle, else low.
// - irq out high while enabled interrupt pending, driven only if mcr enables.
// - loopback tri-states the channel irq output.
// - reset clears the channel irq output inactive.
// - serial output is marking, logic 1, at reset.
// - host data bus driven by device only on reads.
// - modem status reads inverted pins, change flags latch until read.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "ucpc_params.svh"
module ucpc_channel #(
	parameter int DEPTH = 16,
	parameter int TIMEOUT_CYC = (`UCPC_TIMEOUT_NS + `UCPC_CLK_NS - 1) / `UCPC_CLK_NS
) (
	// clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// apb slave
	input wire ucpc_pkg::ucpc_apb_req_t APB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// line side
	input wire ucpc_pkg::ucpc_line_in_t LINE_I,
	input wire logic SERIAL_BIT_I,
	output logic SERIAL_OUT_O,
	// modem pins
	output logic TERMINAL_READY_N_O,
	output logic SEND_REQUEST_N_O,
	// dma pins
	output logic TX_DMA_REQUEST_N_O,
	output logic RX_DMA_REQUEST_N_O,
	// transmit data to serialiser
	output logic [7:0] TX_CHAR_O,
	output logic TX_VALID_O,
	// interrupt pin, three signals
	output logic CHANNEL_IRQ_OUT_O,
	output logic CHANNEL_IRQ_OE_O,
	output logic IRQ_O,
	// transceiver direction
	output logic BUS_READ_DIRECTION_O
);
	import ucpc_pkg::*;
	localparam int AW = $clog2(DEPTH);

	// ************************************
	// pin synchronisers
	// ************************************
	logic [3:0] msr_s1_q;
	logic [3:0] msr_s2_q;
	logic [3:0] msr_prev_q;
	logic rxv_s1_q;
	logic rxv_s2_q;
	logic rxv_prev_q;
	logic txt_s1_q;
	logic txt_s2_q;
	logic txt_prev_q;
	logic [7:0] rxc_s1_q;
	logic [7:0] rxc_s2_q;
	logic ser_s1_q;
	logic ser_s2_q;
	always_ff @(posedge CLK_I)
	begin
		msr_s1_q <= LINE_I.msr_n;
		msr_s2_q <= msr_s1_q;
		rxv_s1_q <= LINE_I.rx_valid;
		rxv_s2_q <= rxv_s1_q;
		rxc_s1_q <= LINE_I.rx_char;
		rxc_s2_q <= rxc_s1_q;
		txt_s1_q <= LINE_I.tx_taken;
		txt_s2_q <= txt_s1_q;
		ser_s1_q <= SERIAL_BIT_I;
		ser_s2_q <= ser_s1_q;
		msr_prev_q <= msr_s2_q;
		rxv_prev_q <= rxv_s2_q;
		txt_prev_q <= txt_s2_q;
	end
	// valid and taken are levels; rising edges mark one event each
	wire rx_push = rxv_s2_q && !rxv_prev_q;
	wire tx_pop_ev = txt_s2_q && !txt_prev_q;

	// ************************************
	// apb decode
	// ************************************
	wire setup = APB_I.psel && !APB_I.penable;
	wire access = APB_I.psel && APB_I.penable;
	logic rdy_q;
	// writes and pops act only at the ready edge, so a held access acts once
	wire wr = access && APB_I.pwrite && rdy_q;
	wire rd = access && !APB_I.pwrite && rdy_q;
	// read data and clear-on-read flags are captured at the first access edge
	wire rd_lat = access && !APB_I.pwrite && !rdy_q;
	wire [7:0] wd = APB_I.pwdata[7:0];
	wire hit_mcr = APB_I.paddr == `UCPC_ADDR_MCR;
	wire hit_fcr = APB_I.paddr == `UCPC_ADDR_FCR;
	wire hit_msr = APB_I.paddr == `UCPC_ADDR_MSR;
	wire hit_txw = APB_I.paddr == `UCPC_ADDR_TXW;
	wire hit_rxr = APB_I.paddr == `UCPC_ADDR_RXR;
	wire hit_lvl = APB_I.paddr == `UCPC_ADDR_LVL;
	wire hit_ist = APB_I.paddr == `UCPC_ADDR_IST;
	wire hit_icl = APB_I.paddr == `UCPC_ADDR_ICL;
	wire hit_ien = APB_I.paddr == `UCPC_ADDR_IEN;
	wire hit_rxp = APB_I.paddr == `UCPC_ADDR_RXP;
	wire mapped = hit_mcr | hit_fcr | hit_msr | hit_txw | hit_rxr | hit_lvl
		| hit_ist | hit_icl | hit_ien | hit_rxp;

	// ************************************
	// control registers
	// ************************************
	logic [7:0] mcr_q;
	logic [7:0] fcr_q;
	logic [4:0] trig_q;
	logic [3:0] ien_q;
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			mcr_q <= `UCPC_MCR_RST;
			fcr_q <= `UCPC_FCR_RST;
			trig_q <= `UCPC_TRIG_RST;
			ien_q <= 4'h0;
		end
		else if (wr)
		begin
			if (hit_mcr)
				mcr_q <= {3'h0, wd[4:0]};
			if (hit_fcr)
				fcr_q <= {4'h0, wd[3], 2'h0, wd[0]};
			if (hit_rxp)
				trig_q <= wd[4:0];
			if (hit_ien)
				ien_q <= wd[3:0];
		end
	end
	wire loop = mcr_q[`UCPC_MCR_LOOP];
	wire fifo_on = fcr_q[`UCPC_FCR_FEN];
	wire dma_type = fifo_on && fcr_q[`UCPC_FCR_DMA];
	// character mode holds a single character
	wire [AW:0] cap = fifo_on ? (AW+1)'(DEPTH) : (AW+1)'(1);

	// ************************************
	// fifos, sixteen deep
	// ************************************
	logic [7:0] txm [DEPTH];
	logic [7:0] rxm [DEPTH];
	logic [AW-1:0] txw_q;
	logic [AW-1:0] txr_q;
	logic [AW-1:0] rxw_q;
	logic [AW-1:0] rxr_q;
	logic [AW:0] txn_q;
	logic [AW:0] rxn_q;
	logic txb_q;
	wire tx_full = txn_q >= cap;
	wire rx_full = rxn_q >= cap;
	wire tx_push = wr && hit_txw && !tx_full;
	wire tx_pop = tx_pop_ev && txn_q != '0;
	wire rx_wr = rx_push && !rx_full;
	wire rx_pop = rd && hit_rxr && rxn_q != '0;
	wire fifo_wr_cfg = wr && hit_fcr;
	always_ff @(posedge CLK_I)
	begin
		if (tx_push)
			txm[txw_q] <= wd;
		if (rx_wr)
			rxm[rxw_q] <= rxc_s2_q;
	end
	always_ff @(posedge CLK_I)
	begin
		if (RST_I || fifo_wr_cfg)
		begin
			txw_q <= '0;
			txr_q <= '0;
			txn_q <= '0;
			rxw_q <= '0;
			rxr_q <= '0;
			rxn_q <= '0;
		end
		else
		begin
			txw_q <= tx_push ? txw_q + 1'b1 : txw_q;
			txr_q <= tx_pop ? txr_q + 1'b1 : txr_q;
			txn_q <= txn_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
			rxw_q <= rx_wr ? rxw_q + 1'b1 : rxw_q;
			rxr_q <= rx_pop ? rxr_q + 1'b1 : rxr_q;
			rxn_q <= rxn_q + (AW+1)'(rx_wr) - (AW+1)'(rx_pop);
		end
	end

	// ************************************
	// character timeout
	// ************************************
	// restarts on any rx fifo push or pop and holds clear while rx is empty; fires once per quiet spell
	logic [$clog2(TIMEOUT_CYC+1)-1:0] to_cnt_q;
	logic to_q;
	wire to_hit = to_cnt_q == ($clog2(TIMEOUT_CYC+1))'(TIMEOUT_CYC);
	always_ff @(posedge CLK_I)
	begin
		if (RST_I || rxn_q == '0 || rx_wr || rx_pop)
		begin
			to_cnt_q <= '0;
			to_q <= 1'b0;
		end
		else if (!to_hit)
			to_cnt_q <= to_cnt_q + 1'b1;
		else
			to_q <= 1'b1;
	end

	// ************************************
	// dma requests
	// ************************************
	logic rx_arm_q;
	wire rx_trig = rxn_q >= {1'b0, trig_q[AW-1:0]} && rxn_q != '0;
	always_ff @(posedge CLK_I)
	begin
		if (RST_I || rxn_q == '0)
			rx_arm_q <= 1'b0;
		else if (rx_trig || to_q)
			rx_arm_q <= 1'b1;
	end
	// type 0 drops after the first load; rises again only once drained
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			txb_q <= 1'b0;
		else if (txn_q == '0 && !tx_push)
			txb_q <= 1'b0;
		else
			txb_q <= 1'b1;
	end
	wire tx_req = dma_type ? !tx_full : !txb_q;
	wire rx_req = dma_type ? rx_arm_q : rxn_q != '0;

	// ************************************
	// modem status and interrupts
	// ************************************
	logic [3:0] delta_q;
	logic [3:0] ist_q;
	wire msr_rd = rd_lat && hit_msr;
	wire [3:0] delta_ev = msr_s2_q ^ msr_prev_q;
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			delta_q <= 4'h0;
		else
			delta_q <= delta_ev | (msr_rd ? 4'h0 : delta_q);
	end
	wire [3:0] irq_ev;
	assign irq_ev[`UCPC_IRQ_MODEM] = |delta_ev;
	assign irq_ev[`UCPC_IRQ_RXDATA] = rx_wr;
	assign irq_ev[`UCPC_IRQ_TXEMPTY] = tx_pop && txn_q == (AW+1)'(1);
	assign irq_ev[`UCPC_IRQ_TIMEOUT] = to_hit && !to_q;
	wire [3:0] clr = (wr && hit_icl) ? wd[3:0] : 4'h0;
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			ist_q <= 4'h0;
		else
			ist_q <= irq_ev | (ist_q & ~clr);
	end
	wire pend = |(ist_q & ien_q);

	// ************************************
	// read mux and outputs
	// ************************************
	logic [7:0] rdat;
	always_comb
	begin
		rdat = 8'h00;
		if (hit_mcr)
			rdat = mcr_q;
		if (hit_fcr)
			rdat = fcr_q;
		if (hit_msr)
			rdat = {~msr_s2_q, delta_q};
		if (hit_rxr)
			rdat = rxm[rxr_q];
		if (hit_lvl)
			rdat = {3'h0, rxn_q[AW:0] == '0, tx_full, rx_req, tx_req, 1'b0};
		if (hit_ist)
			rdat = {4'h0, ist_q};
		if (hit_ien)
			rdat = {4'h0, ien_q};
		if (hit_rxp)
			rdat = {3'h0, trig_q};
	end
	// registered read data: one wait state per access
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			rdy_q <= 1'b0;
			PRDATA_O <= 32'h0;
			PSLVERR_O <= 1'b0;
		end
		else
		begin
			rdy_q <= access && !rdy_q;
			PRDATA_O <= (access && !APB_I.pwrite && !rdy_q) ? {24'h0, rdat} : 32'h0;
			PSLVERR_O <= access && !rdy_q && !mapped;
		end
	end
	assign PREADY_O = rdy_q;
	// modem handshake pins
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			TERMINAL_READY_N_O <= 1'b1;
			SEND_REQUEST_N_O <= 1'b1;
		end
		else
		begin
			TERMINAL_READY_N_O <= loop || !mcr_q[`UCPC_MCR_DTR];
			SEND_REQUEST_N_O <= loop || !mcr_q[`UCPC_MCR_RTS];
		end
	end
	// dma request pins
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			TX_DMA_REQUEST_N_O <= 1'b1;
			RX_DMA_REQUEST_N_O <= 1'b1;
		end
		else
		begin
			TX_DMA_REQUEST_N_O <= !tx_req;
			RX_DMA_REQUEST_N_O <= !rx_req;
		end
	end
	// interrupt pin and its enable
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			CHANNEL_IRQ_OUT_O <= 1'b0;
			CHANNEL_IRQ_OE_O <= 1'b0;
			IRQ_O <= 1'b0;
		end
		else
		begin
			CHANNEL_IRQ_OUT_O <= pend;
			CHANNEL_IRQ_OE_O <= mcr_q[`UCPC_MCR_IRQEN] && !loop;
			IRQ_O <= pend;
		end
	end
	// line and transceiver side
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			SERIAL_OUT_O <= 1'b1;
			BUS_READ_DIRECTION_O <= 1'b0;
			TX_CHAR_O <= 8'h00;
			TX_VALID_O <= 1'b0;
		end
		else
		begin
			// loopback keeps the line marking; serialiser data otherwise
			SERIAL_OUT_O <= loop ? 1'b1 : ser_s2_q;
			BUS_READ_DIRECTION_O <= (setup || access) && !APB_I.pwrite;
			TX_CHAR_O <= txm[txr_q];
			TX_VALID_O <= txn_q != '0;
		end
	end
endmodule
`default_nettype wire

// *** logic/ucpc_params.svh ***
// constants for the serial channel pin control block
// assumes inclusion by bare name from the channel module, the assertions and the bench
`ifndef UCPC_PARAMS_SVH
`define UCPC_PARAMS_SVH
// register byte addresses on apb
`define UCPC_ADDR_MCR 12'h000
`define UCPC_ADDR_FCR 12'h004
`define UCPC_ADDR_MSR 12'h008
`define UCPC_ADDR_TXW 12'h00c
`define UCPC_ADDR_RXR 12'h010
`define UCPC_ADDR_LVL 12'h014
`define UCPC_ADDR_IST 12'h018
`define UCPC_ADDR_ICL 12'h01c
`define UCPC_ADDR_IEN 12'h020
`define UCPC_ADDR_RXP 12'h024
// modem control fields
`define UCPC_MCR_DTR 0
`define UCPC_MCR_RTS 1
`define UCPC_MCR_IRQEN 3
`define UCPC_MCR_LOOP 4
// fifo control fields
`define UCPC_FCR_FEN 0
`define UCPC_FCR_DMA 3
// interrupt status bit positions
`define UCPC_IRQ_MODEM 0
`define UCPC_IRQ_RXDATA 1
`define UCPC_IRQ_TXEMPTY 2
`define UCPC_IRQ_TIMEOUT 3
// reset values
`define UCPC_MCR_RST 8'h00
`define UCPC_FCR_RST 8'h00
`define UCPC_TRIG_RST 5'h01
// character timeout and clock period in ns
`define UCPC_TIMEOUT_NS 40000
`define UCPC_CLK_NS 10
`endif

// *** logic/ucpc_pkg.sv ***
// types for the serial channel pin control block
// assumes ucpc_params.svh on the include path
package ucpc_pkg;
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} ucpc_apb_req_t;
	typedef struct packed {
		logic [3:0] msr_n;
		logic rx_valid;
		logic [7:0] rx_char;
		logic tx_taken;
	} ucpc_line_in_t;
	typedef enum logic [1:0] {UCPC_IDLE, UCPC_READ, UCPC_WRITE} ucpc_acc_t;
endpackage

// *** sim/ucpc_props.sv ***
// assertions on the channel pin control ports
// assumes a bind onto ucpc_channel; apb held until pready
`timescale 1ns/1ns
`default_nettype none
`include "ucpc_params.svh"
module ucpc_props (
	// clock, reset, bus
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire ucpc_pkg::ucpc_apb_req_t APB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	// pins
	input wire logic SERIAL_OUT_O,
	input wire logic TERMINAL_READY_N_O,
	input wire logic SEND_REQUEST_N_O,
	input wire logic CHANNEL_IRQ_OUT_O,
	input wire logic CHANNEL_IRQ_OE_O,
	input wire logic IRQ_O,
	input wire logic BUS_READ_DIRECTION_O
);
	import ucpc_pkg::*;
	// ****
	// shadow of the modem control register
	// ****
	logic [7:0] mcr_q;
	logic done;
	logic rd_req;
	logic loop;
	assign done = APB_I.psel && APB_I.penable && APB_I.pwrite && PREADY_O;
	assign rd_req = APB_I.psel && !APB_I.pwrite;
	assign loop = mcr_q[`UCPC_MCR_LOOP];
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			mcr_q <= 8'h00;
		else if (done && APB_I.paddr == `UCPC_ADDR_MCR)
			mcr_q <= APB_I.pwdata[7:0];
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// settle window: the pins follow a register write one cycle later
	sequence s_mcr; $stable(mcr_q)[*3]; endsequence
	a_dtr_level:
	assert property (s_mcr |-> TERMINAL_READY_N_O != (mcr_q[0] && !loop)) else $error("dtr");
	a_rts_level:
	assert property (s_mcr |-> SEND_REQUEST_N_O != (mcr_q[1] && !loop)) else $error("rts");
	a_irq_gate:
	assert property (s_mcr |-> CHANNEL_IRQ_OE_O == (mcr_q[3] && !loop)) else $error("irq oe");
	a_irq_follow:
	assert property (CHANNEL_IRQ_OE_O |-> CHANNEL_IRQ_OUT_O == IRQ_O) else $error("irq out");
	a_reset_state:
	assert property ($fell(RST_I) |-> TERMINAL_READY_N_O && SEND_REQUEST_N_O && SERIAL_OUT_O
		&& !CHANNEL_IRQ_OE_O && !CHANNEL_IRQ_OUT_O) else $error("reset state");
	a_dir_read:
	assert property (rd_req |=> BUS_READ_DIRECTION_O) else $error("dir low in read");
	a_dir_idle:
	assert property (!rd_req |=> !BUS_READ_DIRECTION_O) else $error("dir high");
	a_rdata_idle:
	assert property (!PREADY_O |-> PRDATA_O == 32'h0) else $error("rdata driven");
	a_err_ready:
	assert property (PSLVERR_O |-> PREADY_O) else $error("err alone");
	cover property (done && APB_I.paddr == `UCPC_ADDR_MCR);
	cover property (CHANNEL_IRQ_OE_O && CHANNEL_IRQ_OUT_O);
	cover property (PSLVERR_O);
endmodule
bind ucpc_channel ucpc_props ucpc_props_inst (.CLK_I, .RST_I, .APB_I, .PRDATA_O, .PREADY_O,
	.PSLVERR_O, .SERIAL_OUT_O, .TERMINAL_READY_N_O, .SEND_REQUEST_N_O, .CHANNEL_IRQ_OUT_O,
	.CHANNEL_IRQ_OE_O, .IRQ_O, .BUS_READ_DIRECTION_O);
`default_nettype wire

// *** sim/ucpc_partner.sv ***
// far side model: modem pins, receive line, serialiser taking chars
// assumes send_i pulses one cycle per received char
`timescale 1ns/1ns
`default_nettype none
module ucpc_partner (
	// clock, reset, bench commands
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic send_i,
	input wire logic [7:0] char_i,
	input wire logic [3:0] pins_n_i,
	input wire logic stall_i,
	// device side
	input wire logic tx_valid_i,
	output var ucpc_pkg::ucpc_line_in_t line_o
);
	import ucpc_pkg::*;
	// ****
	// four cycles a phase, slow enough for the synchronisers
	// ****
	logic [2:0] rx_q;
	logic [2:0] tx_q;
	logic [7:0] char_q;
	// released data line shows the inverse, never a stale char
	assign line_o = '{pins_n_i, rx_q > 3'd3, rx_q > 3'd3 ? char_q : ~char_q, tx_q > 3'd3};
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_q <= 3'd0;
			tx_q <= 3'd0;
			char_q <= 8'h00;
		end
		else
		begin
			if (send_i)
				char_q <= char_i;
			rx_q <= send_i ? 3'd7 : rx_q - {2'b00, rx_q != 3'd0};
			if (tx_q != 3'd0)
				tx_q <= tx_q - 3'd1;
			else if (tx_valid_i && !stall_i)
				tx_q <= 3'd7;
		end
	end
endmodule
`default_nettype wire

// *** sim/uart_channel_pin_control_tb.sv ***
// self-checking bench for the serial channel pin control block
// assumes the partner model on the line side, apb driven from here
`timescale 1ns/1ns
`default_nettype none
`include "ucpc_params.svh"
module uart_channel_pin_control_tb;
	import ucpc_pkg::*;
	// ****
	// stimulus, queue model, comparisons
	// ****
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic SERIAL_BIT_I = 1'b1;
	logic send = 1'b0;
	logic stall = 1'b0;
	logic [7:0] chr = 8'h00;
	logic [3:0] pins_n = 4'hf;
	ucpc_apb_req_t apb_req = '0;
	ucpc_line_in_t line;
	logic [31:0] PRDATA_O, r;
	logic [7:0] TX_CHAR_O, c;
	logic PREADY_O, PSLVERR_O, SERIAL_OUT_O, TERMINAL_READY_N_O, SEND_REQUEST_N_O, TX_VALID_O;
	logic TX_DMA_REQUEST_N_O, RX_DMA_REQUEST_N_O, CHANNEL_IRQ_OUT_O, CHANNEL_IRQ_OE_O;
	logic IRQ_O, BUS_READ_DIRECTION_O, err;
	logic [7:0] txq[$], rxq[$];
	int n_errors = 0, checks = 0, i;
	ucpc_channel #(.TIMEOUT_CYC(20)) ucpc_channel_inst (.CLK_I, .RST_I, .APB_I(apb_req),
		.PRDATA_O, .PREADY_O, .PSLVERR_O, .LINE_I(line), .SERIAL_BIT_I, .SERIAL_OUT_O,
		.TERMINAL_READY_N_O, .SEND_REQUEST_N_O, .TX_DMA_REQUEST_N_O, .RX_DMA_REQUEST_N_O,
		.TX_CHAR_O, .TX_VALID_O, .CHANNEL_IRQ_OUT_O, .CHANNEL_IRQ_OE_O, .IRQ_O,
		.BUS_READ_DIRECTION_O);
	ucpc_partner ucpc_partner_inst (.clk_i(CLK_I), .rst_i(RST_I), .send_i(send),
		.char_i(chr), .pins_n_i(pins_n), .stall_i(stall), .tx_valid_i(TX_VALID_O), .line_o(line));
	initial
	begin
		forever #5 CLK_I = ~CLK_I;
	end
	always @(posedge CLK_I)
		SERIAL_BIT_I <= 1'($urandom);
	always @(posedge line.tx_taken)
		cmp_val({24'h0, TX_CHAR_O}, txq.size() ? {24'h0, txq.pop_front()} : 32'hx);
	task automatic conclude();
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_pin(input logic g, input logic e);
		cmp_val({31'h0, g}, {31'h0, e});
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK_I);
		apb_req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge CLK_I);
		apb_req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge CLK_I);
			n++;
		end
		while (PREADY_O !== 1'b1 && n < 20);
		if (PREADY_O !== 1'b1)
		begin
			n_errors++;
			conclude();
		end
		r = PRDATA_O;
		err = PSLVERR_O;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp_val(r, e);
	endtask
	// bounded wait on a dma request pin, a timeout ends the run
	task automatic wt(input logic rx, input logic v);
		int n;
		for (n = 0; n < 300 && (rx ? RX_DMA_REQUEST_N_O : TX_DMA_REQUEST_N_O) !== v; n++)
			@(posedge CLK_I);
		cmp_pin(rx ? RX_DMA_REQUEST_N_O : TX_DMA_REQUEST_N_O, v);
		if (n == 300)
			conclude();
	endtask
	task automatic send_char(input logic [7:0] x);
		send <= 1'b1;
		chr <= x;
		rxq.push_back(x);
		@(posedge CLK_I);
		send <= 1'b0;
		repeat (9) @(posedge CLK_I);
	endtask
	initial
	begin
		void'($urandom(32'he6b4));
		repeat (16) @(posedge CLK_I);
		RST_I <= 1'b0;
		rd(`UCPC_ADDR_MCR, 32'h0);
		rd(`UCPC_ADDR_RXP, 32'h1);
		apb(1'b0, 12'h0f0, 32'h0);
		cmp_pin(err, 1'b1);
		cmp_val(r, 32'h0);
		for (i = 0; i < 32; i++)
		begin
			apb(1'b1, `UCPC_ADDR_MCR, 32'(i));
			repeat (4) @(posedge CLK_I);
			cmp_pin(TERMINAL_READY_N_O, !(i[0] && !i[4]));
			cmp_pin(SEND_REQUEST_N_O, !(i[1] && !i[4]));
			cmp_pin(CHANNEL_IRQ_OE_O, i[3] && !i[4]);
		end
		// type bit without fifo mode must still signal type 0
		apb(1'b1, `UCPC_ADDR_MCR, 32'h0);
		stall <= 1'b1;
		apb(1'b1, `UCPC_ADDR_FCR, 32'h8);
		wt(1'b0, 1'b0);
		c = 8'($urandom);
		txq.push_back(c);
		apb(1'b1, `UCPC_ADDR_TXW, {24'h0, c});
		wt(1'b0, 1'b1);
		stall <= 1'b0;
		wt(1'b0, 1'b0);
		stall <= 1'b1;
		apb(1'b1, `UCPC_ADDR_FCR, 32'h9);
		for (i = 0; i < 17; i++)
		begin
			c = 8'($urandom);
			if (i < 16)
				txq.push_back(c);
			apb(1'b1, `UCPC_ADDR_TXW, {24'h0, c});
			repeat (3) @(posedge CLK_I);
			cmp_pin(TX_DMA_REQUEST_N_O, i >= 15);
		end
		stall <= 1'b0;
		for (i = 0; i < 500 && txq.size() > 0; i++)
			@(posedge CLK_I);
		cmp_val(txq.size(), 32'h0);
		apb(1'b1, `UCPC_ADDR_RXP, 32'h4);
		for (i = 0; i < 4; i++)
		begin
			cmp_pin(RX_DMA_REQUEST_N_O, 1'b1);
			send_char(8'($urandom));
		end
		wt(1'b1, 1'b0);
		while (rxq.size() > 0)
		begin
			cmp_pin(RX_DMA_REQUEST_N_O, 1'b0);
			rd(`UCPC_ADDR_RXR, {24'h0, rxq.pop_front()});
		end
		wt(1'b1, 1'b1);
		send_char(8'($urandom));
		cmp_pin(RX_DMA_REQUEST_N_O, 1'b1);
		wt(1'b1, 1'b0);
		rd(`UCPC_ADDR_RXR, {24'h0, rxq.pop_front()});
		apb(1'b1, `UCPC_ADDR_FCR, 32'h0);
		apb(1'b1, `UCPC_ADDR_ICL, 32'hf);
		apb(1'b1, `UCPC_ADDR_IEN, 32'h2);
		apb(1'b1, `UCPC_ADDR_MCR, 32'h8);
		send_char(8'($urandom));
		wt(1'b1, 1'b0);
		repeat (2) @(posedge CLK_I);
		cmp_pin(CHANNEL_IRQ_OUT_O, 1'b1);
		rd(`UCPC_ADDR_LVL, 32'h6);
		apb(1'b1, `UCPC_ADDR_IEN, 32'h0);
		repeat (2) @(posedge CLK_I);
		cmp_pin(IRQ_O, 1'b0);
		rd(`UCPC_ADDR_RXR, {24'h0, rxq.pop_front()});
		wt(1'b1, 1'b1);
		apb(1'b1, `UCPC_ADDR_ICL, 32'hf);
		apb(1'b1, `UCPC_ADDR_IEN, 32'h2);
		repeat (2) @(posedge CLK_I);
		cmp_pin(IRQ_O, 1'b0);
		apb(1'b0, `UCPC_ADDR_MSR, 32'h0);
		pins_n <= 4'hc;
		repeat (6) @(posedge CLK_I);
		rd(`UCPC_ADDR_MSR, 32'h33);
		rd(`UCPC_ADDR_MSR, 32'h30);
		rd(`UCPC_ADDR_IST, 32'h1);
		conclude();
	end
endmodule
`default_nettype wire
